// *** shared/adc_port_pkg.sv ***
// Shared constants and carrier types for the converter output port.
// Assumes a single sample clock of 10 MHz that also clocks all logic.
package adc_port_pkg;
  localparam int DATA_W = 12;
  localparam int MSB_POS = DATA_W - 1;
  localparam int PIPE_DEPTH = 6;
  localparam int SYNC_LEN = 3;
  localparam int CLK_PERIOD_NS = 100;
  // Reference recharge time after standby; depends on bypass capacitors
  localparam int RECOVER_TIME_NS = 10000;
  // Longest-time style figure rounds down, never below one cycle
  localparam int RECOVER_CYCLES_DEF = (RECOVER_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                      (RECOVER_TIME_NS / CLK_PERIOD_NS);
  localparam int CNT_W = 16;

  typedef enum logic [1:0] {ST_STANDBY, ST_RECOVER, ST_RUN} mode_e;

  typedef struct packed {
    logic [SYNC_LEN-1:0] oe_n_sync;
    logic [SYNC_LEN-1:0] stby_sync;
    logic oe_n;
    logic stby;
  } pin_sync_s;

  typedef struct packed {
    logic [PIPE_DEPTH-1:0][DATA_W-1:0] word;
    logic [PIPE_DEPTH-1:0] valid;
  } pipe_s;

  typedef struct packed {
    pin_sync_s pins;
    mode_e mode;
    logic [CNT_W-1:0] recover_cnt;
  } port_state_s;
endpackage

// *** hdl/conv_pipe.sv ***
// Conversion pipeline: each sample clock outside flush pushes one word in and one out.
// Assumes the sample word arrives in two's complement from the core.
`timescale 1ns/1ps
`default_nettype none
module conv_pipe
  import adc_port_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [DATA_W-1:0] sample_i,
  input wire logic accurate_i,
  input wire logic flush_i,
  output logic [DATA_W-1:0] word_o,
  output logic valid_o,
  output logic [PIPE_DEPTH-1:0] fill_o
);
  pipe_s st_ff;
  pipe_s nxt_st;

  // Shift one stage per clock outside standby; standby destroys every result in flight
  always_comb
  begin
    nxt_st = st_ff;
    if (flush_i)
    begin
      nxt_st.valid = '0;
    end
    else
    begin
      // Offset binary is two's complement with the sign bit flipped
      nxt_st.word[0] = {~sample_i[MSB_POS], sample_i[MSB_POS-1:0]};
      nxt_st.valid[0] = accurate_i;
      for (int i = 1; i < PIPE_DEPTH; i++)
      begin
        nxt_st.word[i] = st_ff.word[i-1];
        nxt_st.valid[i] = st_ff.valid[i-1];
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign word_o = st_ff.word[PIPE_DEPTH-1];
  assign valid_o = st_ff.valid[PIPE_DEPTH-1];
  assign fill_o = st_ff.valid;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_offset_binary: assert property (!flush_i |=> st_ff.word[0] ==
    {~$past(sample_i[MSB_POS]), $past(sample_i[MSB_POS-1:0])})
    else $error("first stage word is not offset binary");
  a_flush_clears: assert property (flush_i |=> fill_o == '0)
    else $error("standby left valid words in the pipeline");
endmodule
`default_nettype wire

// *** hdl/adc_output_port.sv ***
// Digital side of a pipelined 12-bit converter: pins, standby, output port.
// Assumes mclk_i is the sample clock; enable and standby pins are asynchronous.
// Assumes the sample core hands over one two's complement word per rising edge.
// Assumes a monitor outside flags a stopped or too slow clock on charge_lost_i.
// Operation
// - Stopped or too slow clock loses internal charge; accuracy degrades.
// - Output enable high floats all data pins.
// - Output enable low drives the data pins.
// - Conversion continues whatever the output enable level.
// - Standby request high holds low-power state without useful conversion.
// - Data pins are undefined during standby, not samples.
// - Entering standby corrupts every sample in the pipeline.
// - After standby, reference recharge interval precedes accurate conversions.
// - Valid offset-binary words appear while enable and standby are low.
`timescale 1ns/1ps
`default_nettype none
module adc_output_port
  import adc_port_pkg::*;
#(
  parameter int RECOVER_CYCLES = RECOVER_CYCLES_DEF
)
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic oe_n_i,
  input wire logic standby_request_i,
  input wire logic [DATA_W-1:0] sample_i,
  input wire logic charge_lost_i,
  output logic [DATA_W-1:0] data_o,
  output logic data_oe_o,
  output logic data_valid_o,
  output logic accurate_o
);
  // Registered state, its next value and what the pipeline reports back
  port_state_s st_ff;
  port_state_s nxt_st;
  logic [DATA_W-1:0] pipe_word;
  logic pipe_valid;
  logic [PIPE_DEPTH-1:0] pipe_fill;
  logic run_now;
  logic flush;

  localparam logic [CNT_W-1:0] RECOVER_LAST = CNT_W'(RECOVER_CYCLES - 1);

  // Only samples taken in full operation are tagged accurate
  assign run_now = (st_ff.mode == ST_RUN);
  assign flush = (st_ff.mode == ST_STANDBY);

  // Next filtered level of a pin: it moves only when stages two and three agree.
  // Stage one may be metastable, so it is never read; a one-cycle glitch on the
  // pin is lost here, which costs one to two cycles of latency on every change.
  function automatic logic settle_pin(input logic [SYNC_LEN-1:0] sync,
                                      input logic cur);
    logic settled;
    settled = cur;
    if (sync[SYNC_LEN-2] == sync[SYNC_LEN-1])
      settled = sync[SYNC_LEN-1];
    return settled;
  endfunction

  // Pin filtering, then standby and recovery sequencing
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.pins.oe_n_sync = {st_ff.pins.oe_n_sync[SYNC_LEN-2:0], oe_n_i};
    nxt_st.pins.stby_sync = {st_ff.pins.stby_sync[SYNC_LEN-2:0], standby_request_i};
    // Both pins share one filter; the enable steers the pin drivers and gates the valid flag
    nxt_st.pins.oe_n = settle_pin(st_ff.pins.oe_n_sync, st_ff.pins.oe_n);
    nxt_st.pins.stby = settle_pin(st_ff.pins.stby_sync, st_ff.pins.stby);
    // Mode sequencing: standby, then recovery, then full operation
    unique case (st_ff.mode)
      ST_STANDBY:
      begin
        // Words in flight are already marked invalid; wait for the release
        if (!st_ff.pins.stby)
        begin
          nxt_st.mode = ST_RECOVER;
          nxt_st.recover_cnt = '0;
        end
      end
      ST_RECOVER:
      begin
        // Standby wins over lost charge, and lost charge over the count
        if (st_ff.pins.stby)
          nxt_st.mode = ST_STANDBY;
        else if (charge_lost_i)
          nxt_st.recover_cnt = '0;
        else if (st_ff.recover_cnt == RECOVER_LAST)
          nxt_st.mode = ST_RUN;
        else
          nxt_st.recover_cnt = st_ff.recover_cnt + CNT_W'(1);
      end
      ST_RUN:
      begin
        // Output enable is not looked at here: conversion never pauses for it
        if (st_ff.pins.stby)
          nxt_st.mode = ST_STANDBY;
        else if (charge_lost_i)
        begin
          // A stalled or slow clock drains the hold charge, so recharge again
          nxt_st.mode = ST_RECOVER;
          nxt_st.recover_cnt = '0;
        end
      end
    endcase
  end

  // Reset lands in recovery since reference charge is unknown at power-up
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_ff <= '0;
      st_ff.pins.oe_n_sync <= '1;
      st_ff.pins.oe_n <= 1'b1;
      st_ff.mode <= ST_RECOVER;
    end
    else
      st_ff <= nxt_st;
  end

  // Samples enter every edge outside standby whatever the enable does; only samples taken in
  // full operation carry a valid tag down the pipeline
  conv_pipe u_pipe (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .sample_i(sample_i),
    .accurate_i(run_now),
    .flush_i(flush),
    .word_o(pipe_word),
    .valid_o(pipe_valid),
    .fill_o(pipe_fill)
  );

  // Pin drive follows the filtered enable; data comes from the pipeline register.
  // In standby the last words stay on the pins but are stale: the valid flag is the
  // only thing the capture side may trust, and it drops as soon as the filtered
  // standby level rises, one edge before the mode register follows it.
  assign data_o = pipe_word;
  assign data_oe_o = !st_ff.pins.oe_n;
  assign data_valid_o = pipe_valid && !flush && !st_ff.pins.stby
    && !st_ff.pins.oe_n;
  assign accurate_o = run_now;

  // Every assertion below runs on the sample clock and sleeps through reset
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  // Six steady pin samples outlast the three-stage filter and its output flop
  a_oe_floats: assert property (oe_n_i [*6] |-> !data_oe_o)
    else $error("data pins driven while enable is high");
  a_oe_drives: assert property (!oe_n_i [*6] |-> data_oe_o)
    else $error("data pins floating while enable is low");
  a_convert_on: assert property ((run_now && !st_ff.pins.stby && !charge_lost_i
    && $changed(st_ff.pins.oe_n)) |=> run_now)
    else $error("enable change interrupted conversion");

  // Standby stops conversion, clears the flags and empties the pipeline
  a_standby_enter: assert property (st_ff.pins.stby |=> st_ff.mode == ST_STANDBY)
    else $error("standby request did not stop conversion");
  a_standby_nodata: assert property (flush |-> !data_valid_o)
    else $error("valid flagged during standby");
  a_standby_flush: assert property (flush |=> pipe_fill == '0)
    else $error("pipeline survived standby");

  // Recovery must run to its last count before full operation
  a_recover_wait: assert property ((st_ff.mode == ST_RECOVER &&
    st_ff.recover_cnt != RECOVER_LAST) |=> !run_now)
    else $error("recovery ended early");
  a_valid_gate: assert property (data_valid_o |-> data_oe_o && !st_ff.pins.stby)
    else $error("valid word without enable or during standby");
  a_charge_loss: assert property ((run_now && charge_lost_i && !st_ff.pins.stby)
    |=> st_ff.mode == ST_RECOVER && st_ff.recover_cnt == '0)
    else $error("lost charge did not restart recovery");

  // Lost charge during recovery starts the wait again from zero
  a_charge_restart: assert property ((st_ff.mode == ST_RECOVER && !st_ff.pins.stby
    && charge_lost_i) |=> st_ff.mode == ST_RECOVER && st_ff.recover_cnt == '0)
    else $error("lost charge during recovery did not restart the count");

  // Filtered levels move only to a value the last two stages agreed on
  a_oe_settle: assert property ($changed(st_ff.pins.oe_n) |->
    st_ff.pins.oe_n == $past(st_ff.pins.oe_n_sync[SYNC_LEN-1]))
    else $error("enable level changed without agreeing stages");
  a_stby_settle: assert property ($changed(st_ff.pins.stby) |->
    st_ff.pins.stby == $past(st_ff.pins.stby_sync[SYNC_LEN-1]))
    else $error("standby level changed without agreeing stages");

  // Conversion runs on whatever the enable does; standby holds until released
  a_run_holds: assert property ((run_now && !st_ff.pins.stby && !charge_lost_i)
    |=> run_now)
    else $error("conversion stopped without standby or lost charge");
  a_standby_hold: assert property ((flush && st_ff.pins.stby) |=> flush)
    else $error("standby left while still requested");
  a_words_frozen: assert property (flush |=> $stable(pipe_word))
    else $error("pipeline moved during standby");

  // Leaving standby never shows a word that was in flight when it began
  a_refill_dark: assert property ($fell(flush) |-> (!data_valid_o) [*6])
    else $error("valid word within six cycles of leaving standby");

  // Recovery counts up one per edge from zero, then hands over to full operation
  a_standby_exit: assert property ((flush && !st_ff.pins.stby)
    |=> st_ff.mode == ST_RECOVER && st_ff.recover_cnt == '0)
    else $error("standby release did not start recovery");
  a_recover_count: assert property ((st_ff.mode == ST_RECOVER && !st_ff.pins.stby
    && !charge_lost_i && st_ff.recover_cnt != RECOVER_LAST)
    |=> st_ff.recover_cnt == $past(st_ff.recover_cnt) + CNT_W'(1))
    else $error("recovery count did not advance");
  a_recover_done: assert property ((st_ff.mode == ST_RECOVER && !st_ff.pins.stby
    && !charge_lost_i && st_ff.recover_cnt == RECOVER_LAST) |=> run_now)
    else $error("recovery did not end in full operation");

  // Seven edges of full operation fill the pipeline with accurate words
  a_stream_valid: assert property (run_now [*7] |->
    data_valid_o || st_ff.pins.oe_n || st_ff.pins.stby)
    else $error("steady operation gave no valid word");
endmodule
`default_nettype wire

// *** test/capture_model.sv ***
// Capture logic that sits at the far side of the converter output port.
// Assumes the port's enable and valid flags are settled by the falling edge.
`timescale 1ns/1ps
`default_nettype none
module capture_model
  import adc_port_pkg::*;
#(
  parameter int SKIP = 12
)
(
  input wire logic mclk_i,
  input wire logic [DATA_W-1:0] data_i,
  input wire logic oe_i,
  input wire logic valid_i,
  input wire logic standby_i,
  output logic [DATA_W-1:0] word_o,
  output logic ok_o
);
  int skip = 0;
  // Falling edge sits mid-cycle, far from the port's launch edge
  always @(negedge mclk_i)
  begin
    word_o <= data_i;
    ok_o <= oe_i && valid_i && skip == 0;
    skip <= standby_i ? SKIP : (skip > 0 ? skip - 1 : 0);
  end
endmodule
`default_nettype wire

// *** test/adc_output_port_power_control_test.sv ***
// Self-checking bench for the converter output port and its capture model.
// Assumes one 10 MHz sample clock; inputs change on its falling edge.
`timescale 1ns/1ps
`default_nettype none
module adc_output_port_power_control_test;
  import adc_port_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic oe_n_i = 1'b1;
  logic standby_request_i = 1'b0;
  logic [DATA_W-1:0] sample_i = '0;
  logic charge_lost_i = 1'b0;
  logic [DATA_W-1:0] data_o;
  logic [DATA_W-1:0] cap_word;
  logic data_oe_o;
  logic data_valid_o;
  logic accurate_o;
  logic cap_ok;
  logic [DATA_W-1:0] hist [8];
  int fails = 0;
  int n_compared = 0;
  int seed = 32'h3ef15bc5;
  int r;

  // Steady 50% clock at 100 ns
  always #50 mclk_i = ~mclk_i;

  adc_output_port #(.RECOVER_CYCLES(4)) dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .oe_n_i(oe_n_i), .standby_request_i(standby_request_i), .sample_i(sample_i),
    .charge_lost_i(charge_lost_i), .data_o(data_o), .data_oe_o(data_oe_o),
    .data_valid_o(data_valid_o), .accurate_o(accurate_o));

  // One converter alone drives the capture bus; the enable never shares it
  capture_model cap (.mclk_i(mclk_i), .data_i(data_o), .oe_i(data_oe_o),
    .valid_i(data_valid_o), .standby_i(standby_request_i), .word_o(cap_word), .ok_o(cap_ok));

  function automatic logic [DATA_W-1:0] offs(input logic [DATA_W-1:0] s);
    return {~s[MSB_POS], s[MSB_POS-1:0]};
  endfunction

  task automatic chk(input string what, input logic [DATA_W-1:0] seen,
                     input logic [DATA_W-1:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Random samples with full-scale corners mixed in
  always @(negedge mclk_i)
  begin
    r = $random(seed);
    sample_i <= (r & 3) == 0 ? 12'h800 : (r & 3) == 1 ? 12'h7FF : DATA_W'($random(seed));
  end

  // History of taken samples; a word reaches data_o five edges after it is taken
  always @(posedge mclk_i)
  begin
    for (int i = 7; i > 0; i--)
      hist[i] <= hist[i-1];
    hist[0] <= sample_i;
  end

  // Every captured good word must be the offset form of its sample
  always @(negedge mclk_i)
  begin
    #1;
    if (cap_ok === 1'b1)
      chk("word", cap_word, offs(hist[PIPE_DEPTH-1]));
  end

  initial
  begin
    repeat (8) @(negedge mclk_i);
    rst_n_i = 1'b1;
    oe_n_i = 1'b0;
    repeat (20) @(negedge mclk_i);
    chk("drive", DATA_W'(data_oe_o), 12'h001);
    chk("valid", DATA_W'(data_valid_o), 12'h001);
    repeat (60) @(negedge mclk_i);
    oe_n_i = 1'b1;
    repeat (6) @(negedge mclk_i);
    chk("float", DATA_W'(data_oe_o), 12'h000);
    oe_n_i = 1'b0;
    repeat (6) @(negedge mclk_i);
    chk("resume", DATA_W'(data_valid_o), 12'h001);
    standby_request_i = 1'b1;
    repeat (8) @(negedge mclk_i);
    chk("standby", DATA_W'(data_valid_o), 12'h000);
    chk("stby_acc", DATA_W'(accurate_o), 12'h000);
    standby_request_i = 1'b0;
    repeat (10) @(negedge mclk_i);
    chk("refill", DATA_W'(data_valid_o), 12'h000);
    repeat (30) @(negedge mclk_i);
    chk("back", DATA_W'(data_valid_o), 12'h001);
    charge_lost_i = 1'b1;
    @(negedge mclk_i);
    charge_lost_i = 1'b0;
    @(negedge mclk_i);
    chk("lost", DATA_W'(accurate_o), 12'h000);
    repeat (30) @(negedge mclk_i);
    chk("regain", DATA_W'(accurate_o), 12'h001);
    tally_and_finish();
  end

  // Guard against a hang: the sequence needs under 300 cycles
  initial
  begin
    #(1000 * CLK_PERIOD_NS);
    fails++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
